// ### logic/rbs_cfg.svh
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH

// Clock period in ns at 100 MHz
`define RBS_CLK_NS 10

// Reset pulse thresholds in ns
`define RBS_DIG_MIN_NS 100
`define RBS_DIG_MAX_NS 1000
`define RBS_ANA_MIN_NS 10000

// Least times round up
`define RBS_DIG_MIN_CYC ((`RBS_DIG_MIN_NS + `RBS_CLK_NS - 1) / `RBS_CLK_NS)
`define RBS_ANA_MIN_CYC ((`RBS_ANA_MIN_NS + `RBS_CLK_NS - 1) / `RBS_CLK_NS)

// Strap settle and PLL start-up in us, boot limit in ms
`define RBS_START_US 3000
`define RBS_START_CYC (`RBS_START_US * 1000 / `RBS_CLK_NS)
`define RBS_BOOT_MS 1000
`define RBS_BOOT_CYC (`RBS_BOOT_MS * 1000000 / `RBS_CLK_NS)

// Host serial clock edges that select SPI
`define RBS_SPI_EDGES 2

// Boot sense reset value
`define RBS_SENSE_RST 3'h0

// Strap pin positions
`define RBS_STRAP_CLK_LSB 0
`define RBS_STRAP_CLK_MSB 1
`define RBS_STRAP_BOOT 2

`endif

// ### logic/rbs_pkg.sv
`default_nettype none

package rbs_pkg;

    typedef enum logic [1:0] {
        RBS_CLK_XTAL = 2'h0,
        RBS_CLK_FS8K = 2'h1,
        RBS_CLK_FS16K = 2'h2,
        RBS_CLK_RSVD = 2'h3
    } rbs_clk_src_e;

    typedef struct packed {
        rbs_clk_src_e clk_src;
        logic auto_boot;
    } rbs_sense_s;

    typedef enum logic [2:0] {
        RBS_ST_RESET = 3'h0,
        RBS_ST_SENSE = 3'h1,
        RBS_ST_START = 3'h3,
        RBS_ST_LOCK = 3'h2,
        RBS_ST_LOAD = 3'h6,
        RBS_ST_CONFIG = 3'h7,
        RBS_ST_RUN = 3'h5,
        RBS_ST_FAIL = 3'h4
    } rbs_state_e;

endpackage : rbs_pkg

`default_nettype wire

// ### logic/rbs_reset_boot_sequencer.sv
// Overview of operation
// RL1 - Low 100 ns to 1 us: digital reset
// RL2 - Low over 10 us: analog reset too
// RL3 - Analog release: supply, PLL on, wait start-up
// RL4 - Any reset release reruns full boot
// RL5 - Straps resampled after every reset type
// RL6 - Sense straps, boot starts 3 ms later
// RL7 - Auto Boot operational within one second
// RL8 - Board gives stable clock before release
// RL9 - External mode: enable drives external regulator
// RL10 - Long reset forces supply enable low
// RL11 - Internal mode: enable drives pass FET
// RL12 - Boot loader first captures strap pins
// RL13 - Auto copies, configures, jumps; host fills
// RL14 - Straps one, zero select clock source
// RL15 - Strap two selects host or auto
// RL16 - Unpulled strap reads zero, pull-up one
// RL17 - Strap pins free after sensing
// RL18 - Auto Boot makes pin nine flash select
// RL19 - PLL lock queues event, interrupt low
// RL20 - Two serial clocks select SPI slave
// RL21 - Low 1 to 10 us: digital only
`timescale 1ns/10ps
`default_nettype none

`include "rbs_cfg.svh"

module rbs_reset_boot_sequencer
    import rbs_pkg::*;
#(
    parameter int unsigned START_CYC = `RBS_START_CYC,
    parameter int unsigned BOOT_CYC = `RBS_BOOT_CYC
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rstn,
    // Device pins
    input wire logic reset_pin_n,
    input wire logic supply_source_select,
    input wire logic [2:0] strap_pins,
    input wire logic host_sclk,
    // Analog and loader handshakes
    input wire logic pll_lock,
    input wire logic flash_load_done,
    input wire logic cfg_done,
    input wire logic host_load_done,
    input wire logic host_int_ack,
    // Supply and clock control
    output logic core_supply_enable_out,
    output logic internal_regulator_on,
    output logic pll_enable,
    output logic core_reset_n,
    // Boot results
    output rbs_sense_s boot_sense,
    output logic strap_pins_free,
    output logic gpio9_is_flash_chip_select,
    output logic flash_load_req,
    output logic cfg_write_req,
    output logic jump_to_ram,
    output logic host_event_push,
    output logic host_interrupt_n,
    output logic host_bus_port_spi,
    output logic operational,
    output logic boot_timeout
);

    localparam int unsigned LOW_W = 11;
    localparam logic [LOW_W-1:0] DIG_MIN = LOW_W'(`RBS_DIG_MIN_CYC);
    localparam logic [LOW_W-1:0] ANA_MIN = LOW_W'(`RBS_ANA_MIN_CYC);
    localparam logic [LOW_W-1:0] LOW_SAT = {LOW_W{1'b1}};
    localparam int unsigned TW = 27;

    // Pin synchronisers
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic rst_pin_s;
    logic supply_source_select_s;
    logic [2:0] strap_s;
    logic sclk_s;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // Idle levels: pin high, straps pulled down, no clock, no lock
            sync1_q <= 6'h01;
            sync2_q <= 6'h01;
        end else begin
            sync1_q <= {pll_lock, host_sclk, strap_pins, reset_pin_n} & 6'h3f;
            sync2_q <= sync1_q;
        end
    end

    // Ext select is sampled with the straps below, not on this bank
    logic ext_sync1_q;
    logic ext_sync2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync1_q <= 1'b0;
            ext_sync2_q <= 1'b0;
        end else begin
            ext_sync1_q <= supply_source_select;
            ext_sync2_q <= ext_sync1_q;
        end
    end

    logic lock_s;
    assign rst_pin_s = sync2_q[0];
    assign strap_s = sync2_q[3:1];
    assign sclk_s = sync2_q[4];
    assign lock_s = sync2_q[5];
    assign supply_source_select_s = ext_sync2_q;

    // Sequencer state
    rbs_state_e state_q, state_d;
    logic [LOW_W-1:0] low_q, low_d;
    logic analog_q, analog_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic [TW-1:0] boot_tmr_q, boot_tmr_d;
    logic sclk_prev_q, sclk_prev_d;
    logic [1:0] edges_q, edges_d;
    rbs_sense_s sense_q, sense_d;
    logic ext_mode_q, ext_mode_d;
    logic supply_q, supply_d;
    logic pll_q, pll_d;
    logic core_rst_q, core_rst_d;
    logic free_q, free_d;
    logic fl_req_q, fl_req_d;
    logic cfg_req_q, cfg_req_d;
    logic jump_q, jump_d;
    logic evt_q, evt_d;
    logic int_n_q, int_n_d;
    logic spi_q, spi_d;
    logic run_q, run_d;
    logic tmo_q, tmo_d;
    logic in_reset;

    always_comb begin
        state_d = state_q;
        low_d = low_q;
        analog_d = analog_q;
        tmr_d = tmr_q;
        boot_tmr_d = boot_tmr_q;
        sclk_prev_d = sclk_s;
        edges_d = edges_q;
        sense_d = sense_q;
        ext_mode_d = ext_mode_q;
        fl_req_d = fl_req_q;
        cfg_req_d = cfg_req_q;
        jump_d = 1'b0;
        evt_d = 1'b0;
        int_n_d = int_n_q;
        spi_d = spi_q;
        run_d = run_q;
        tmo_d = tmo_q;
        free_d = free_q;
        in_reset = 1'b0;

        // Pulses under 100 ns are taken as glitches and ignored
        if (!rst_pin_s) begin
            if (low_q != LOW_SAT) begin
                low_d = low_q + LOW_W'(1);
            end
            if (low_q >= DIG_MIN) begin
                in_reset = 1'b1; // [RL1] [RL21]
            end
            if (low_q > ANA_MIN) begin
                analog_d = 1'b1; // [RL2]
            end
        end else begin
            low_d = '0;
            // Supply and PLL come back on the clock edge after the synced pin rises
            analog_d = 1'b0; // [RL3]
        end

        if (in_reset) begin
            state_d = RBS_ST_RESET; // [RL1] [RL4]
            fl_req_d = 1'b0;
            cfg_req_d = 1'b0;
            int_n_d = 1'b1;
            spi_d = 1'b0;
            run_d = 1'b0;
            tmo_d = 1'b0;
            free_d = 1'b0;
            edges_d = '0;
            sense_d = rbs_sense_s'(`RBS_SENSE_RST);
        end else begin
            unique case (state_q)
                RBS_ST_RESET: begin
                    if (rst_pin_s) begin
                        state_d = RBS_ST_SENSE; // [RL4]
                    end
                end
                RBS_ST_SENSE: begin
                    // Absent pull-up reads zero via the pad pull-down
                    sense_d.clk_src = rbs_clk_src_e'(
                        strap_s[`RBS_STRAP_CLK_MSB:`RBS_STRAP_CLK_LSB]); // [RL14] [RL16]
                    sense_d.auto_boot = strap_s[`RBS_STRAP_BOOT]; // [RL15] [RL16]
                    ext_mode_d = supply_source_select_s;
                    free_d = 1'b1; // [RL17]
                    tmr_d = '0;
                    state_d = RBS_ST_START; // [RL5] [RL12]
                end
                RBS_ST_START: begin
                    // One wait covers strap settle and PLL start-up
                    if (tmr_q >= TW'(START_CYC - 1)) begin
                        boot_tmr_d = '0;
                        state_d = RBS_ST_LOCK; // [RL6] [RL3]
                    end else begin
                        tmr_d = tmr_q + TW'(1);
                    end
                end
                RBS_ST_LOCK: begin
                    // Relies on a stable board clock before release
                    if (lock_s) begin // [RL8]
                        evt_d = 1'b1; // [RL19]
                        int_n_d = 1'b0; // [RL19]
                        fl_req_d = sense_q.auto_boot; // [RL13]
                        edges_d = '0;
                        state_d = RBS_ST_LOAD;
                    end
                end
                RBS_ST_LOAD: begin
                    if (sense_q.auto_boot) begin
                        if (flash_load_done) begin
                            fl_req_d = 1'b0;
                            cfg_req_d = 1'b1; // [RL13]
                            state_d = RBS_ST_CONFIG;
                        end
                    end else begin
                        if (sclk_s && !sclk_prev_q && edges_q != 2'h3) begin
                            edges_d = edges_q + 2'h1;
                        end
                        if (edges_q >= 2'(`RBS_SPI_EDGES)) begin
                            spi_d = 1'b1; // [RL20]
                        end
                        if (host_load_done) begin
                            run_d = 1'b1; // [RL13]
                            state_d = RBS_ST_RUN;
                        end
                    end
                end
                RBS_ST_CONFIG: begin
                    if (cfg_done) begin
                        cfg_req_d = 1'b0;
                        jump_d = 1'b1; // [RL13]
                        run_d = 1'b1;
                        state_d = RBS_ST_RUN;
                    end
                end
                RBS_ST_RUN: begin
                end
                RBS_ST_FAIL: begin
                end
                default: begin
                    state_d = RBS_ST_RESET;
                end
            endcase

            // Auto Boot must finish within the limit, else flag and stop
            if (state_q == RBS_ST_LOAD || state_q == RBS_ST_CONFIG) begin
                if (sense_q.auto_boot) begin
                    boot_tmr_d = boot_tmr_q + TW'(1);
                    if (boot_tmr_q >= TW'(BOOT_CYC - 1)) begin
                        tmo_d = 1'b1; // [RL7]
                        fl_req_d = 1'b0;
                        cfg_req_d = 1'b0;
                        state_d = RBS_ST_FAIL;
                    end
                end
            end else if (state_q == RBS_ST_LOCK) begin
                boot_tmr_d = boot_tmr_q + TW'(1);
            end

            if (host_int_ack) begin
                int_n_d = 1'b1;
            end
            if (evt_d) begin
                int_n_d = 1'b0; // [RL19]
            end
        end
    end

    // Supply enable is the same pin in both modes; only its load differs
    assign supply_d = !analog_d; // [RL10] [RL9] [RL11]
    assign pll_d = !analog_d; // [RL2] [RL3]
    assign core_rst_d = !in_reset && state_q != RBS_ST_RESET;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= RBS_ST_RESET;
            low_q <= '0;
            analog_q <= 1'b0;
            tmr_q <= '0;
            boot_tmr_q <= '0;
            sclk_prev_q <= 1'b0;
            edges_q <= '0;
            sense_q <= rbs_sense_s'(`RBS_SENSE_RST);
            ext_mode_q <= 1'b0;
            supply_q <= 1'b1;
            pll_q <= 1'b1;
            core_rst_q <= 1'b0;
            free_q <= 1'b0;
            fl_req_q <= 1'b0;
            cfg_req_q <= 1'b0;
            jump_q <= 1'b0;
            evt_q <= 1'b0;
            int_n_q <= 1'b1;
            spi_q <= 1'b0;
            run_q <= 1'b0;
            tmo_q <= 1'b0;
        end else begin
            state_q <= state_d;
            low_q <= low_d;
            analog_q <= analog_d;
            tmr_q <= tmr_d;
            boot_tmr_q <= boot_tmr_d;
            sclk_prev_q <= sclk_prev_d;
            edges_q <= edges_d;
            sense_q <= sense_d;
            ext_mode_q <= ext_mode_d;
            supply_q <= supply_d;
            pll_q <= pll_d;
            core_rst_q <= core_rst_d;
            free_q <= free_d;
            fl_req_q <= fl_req_d;
            cfg_req_q <= cfg_req_d;
            jump_q <= jump_d;
            evt_q <= evt_d;
            int_n_q <= int_n_d;
            spi_q <= spi_d;
            run_q <= run_d;
            tmo_q <= tmo_d;
        end
    end

    // Internal regulator output flop
    logic int_reg_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_reg_q <= 1'b0;
        end else begin
            int_reg_q <= supply_d && !ext_mode_d; // [RL11]
        end
    end

    assign core_supply_enable_out = supply_q;
    assign internal_regulator_on = int_reg_q;
    assign pll_enable = pll_q;
    assign core_reset_n = core_rst_q;
    assign boot_sense = sense_q;
    assign strap_pins_free = free_q;
    assign gpio9_is_flash_chip_select = sense_q.auto_boot; // [RL18]
    assign flash_load_req = fl_req_q;
    assign cfg_write_req = cfg_req_q;
    assign jump_to_ram = jump_q;
    assign host_event_push = evt_q;
    assign host_interrupt_n = int_n_q;
    assign host_bus_port_spi = spi_q;
    assign operational = run_q;
    assign boot_timeout = tmo_q;

endmodule : rbs_reset_boot_sequencer

`default_nettype wire

// ### tb/rbs_reset_boot_sequencer_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module rbs_reset_boot_sequencer_monitor
    import rbs_pkg::*;
#(
    parameter int unsigned START_CYC = 20,
    parameter int unsigned BOOT_CYC = 200
) (
    // Clock, reset and pins
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_pin_n,
    input wire logic pll_lock,
    // Device outputs
    input wire logic core_supply_enable_out,
    input wire logic pll_enable,
    input wire logic core_reset_n,
    input wire rbs_sense_s boot_sense,
    input wire logic strap_pins_free,
    input wire logic gpio9_is_flash_chip_select,
    input wire logic flash_load_req,
    input wire logic cfg_write_req,
    input wire logic jump_to_ram,
    input wire logic host_event_push,
    input wire logic host_interrupt_n,
    input wire logic host_bus_port_spi,
    input wire logic operational,
    input wire logic boot_timeout
);
    logic [11:0] low_cnt_q;

    // Raw pin low time; thresholds leave room for the two sync flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_q <= 12'h0;
        end else begin
            low_cnt_q <= reset_pin_n ? 12'h0 : low_cnt_q + 12'h1;
        end
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_CORE_HELD: assert property (
        low_cnt_q >= 12'h010 |-> !core_reset_n && !operational) else $error("core running");
    AST_SHORT_KEEPS_SUPPLY: assert property (
        low_cnt_q inside {[12'h001:12'h3de]} |-> core_supply_enable_out) else $error("supply cut");
    AST_LONG_CUTS_SUPPLY: assert property (
        low_cnt_q >= 12'h3f2 |-> !core_supply_enable_out && !pll_enable) else $error("supply on");
    AST_EVENT: assert property (
        host_event_push |-> !host_interrupt_n && $past(pll_lock) ##1 !host_event_push)
        else $error("bad event");
    AST_SENSE_HELD: assert property (
        strap_pins_free && $past(strap_pins_free) |-> $stable(boot_sense)
        && gpio9_is_flash_chip_select == boot_sense.auto_boot) else $error("sense moved");
    AST_FLASH_THEN_CFG: assert property (
        $rose(cfg_write_req) |-> $fell(flash_load_req)) else $error("config before load");
    AST_JUMP: assert property (
        jump_to_ram |-> operational && gpio9_is_flash_chip_select ##1 !jump_to_ram)
        else $error("bad jump");
    AST_TIMEOUT: assert property (
        boot_timeout |-> !flash_load_req && !cfg_write_req && !operational) else $error("timeout");

    cover property (jump_to_ram);
    cover property (host_bus_port_spi && operational);
    cover property (boot_timeout);
    cover property (!core_supply_enable_out);

endmodule : rbs_reset_boot_sequencer_monitor

bind rbs_reset_boot_sequencer rbs_reset_boot_sequencer_monitor #(
    .START_CYC(START_CYC),
    .BOOT_CYC(BOOT_CYC)
) i_rbs_reset_boot_sequencer_monitor (.*);

`default_nettype wire

// ### tb/rbs_host_flash_model.sv
`timescale 1ns/10ps
`default_nettype none

module rbs_host_flash_model (
    // Bench commands
    input wire logic clk,
    input wire logic stall,
    input wire logic use_spi,
    input wire logic [3:0] lat,
    // Device side
    input wire logic pll_enable,
    input wire logic core_reset_n,
    input wire logic flash_load_req,
    input wire logic cfg_write_req,
    input wire logic host_interrupt_n,
    input wire logic gpio9_is_flash_chip_select,
    // Answers
    output logic pll_lock,
    output logic flash_load_done,
    output logic cfg_done,
    output logic host_int_ack,
    output logic host_sclk,
    output logic host_load_done
);
    int wait_c = 0;
    int host_c = 0;

    initial begin
        {pll_lock, flash_load_done, cfg_done, host_int_ack, host_sclk, host_load_done} = 6'h0;
    end

    // Answers move on the falling edge only; a stall never answers a flash load or config write
    always @(negedge clk) begin
        pll_lock <= pll_enable;
        wait_c = (flash_load_req || cfg_write_req) && !stall ? wait_c + 1 : 0;
        flash_load_done <= wait_c > lat && flash_load_req;
        cfg_done <= wait_c > lat && cfg_write_req;
        wait_c = wait_c > lat ? 0 : wait_c;
        host_c = !core_reset_n ? 0 : (host_c > 0 || !host_interrupt_n) ? host_c + 1 : 0;
        host_int_ack <= host_c == 3;
        // Serial clock idles low; two pulses only when the host picks SPI
        host_sclk <= use_spi && !gpio9_is_flash_chip_select && host_c inside {5, 7};
        host_load_done <= !gpio9_is_flash_chip_select && host_c == 12;
        host_c = host_c == 12 ? 0 : host_c;
    end

endmodule : rbs_host_flash_model

`default_nettype wire

// ### tb/reset_boot_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module reset_boot_sequencer_tb
    import rbs_pkg::*;
;
    logic clk, rstn, reset_pin_n, supply_source_select, host_sclk, pll_lock, stall, use_spi;
    logic flash_load_done, cfg_done, host_load_done, host_int_ack;
    logic [2:0] strap_pins;
    logic [3:0] lat;
    logic core_supply_enable_out, internal_regulator_on, pll_enable, core_reset_n;
    logic strap_pins_free, gpio9_is_flash_chip_select, flash_load_req, cfg_write_req;
    logic jump_to_ram, host_event_push, host_interrupt_n, host_bus_port_spi;
    logic operational, boot_timeout;
    rbs_sense_s boot_sense;
    int errors = 0;
    int num_checks = 0;
    int hung = 0;
    int exp_q[$];
    int lows[4] = '{20, 100, 500, 1100};

    rbs_reset_boot_sequencer #(.START_CYC(20), .BOOT_CYC(200)) i_rbs_reset_boot_sequencer (.*);
    rbs_host_flash_model i_rbs_host_flash_model (.*);

    // Board clock runs before and through every reset release
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic run(input int low, input logic [2:0] s, input logic sel, input logic spi,
                       input logic st);
        int n;
        int es;
        // After a hang the remaining scenarios are skipped
        if (hung != 0) begin
            return;
        end
        strap_pins = s;
        supply_source_select = sel;
        use_spi = spi;
        stall = st;
        lat = 4'($urandom_range(9, 1));
        // Reference: sense, operational, bus mode, timeout
        exp_q.push_back({s[1:0], s[2]});
        exp_q.push_back(!(s[2] && st));
        exp_q.push_back(!s[2] && spi);
        exp_q.push_back(s[2] && st);
        if (low > 0) begin
            reset_pin_n = 1'b0;
            repeat (low) @(negedge clk);
            check(8'(core_reset_n), 8'h0);
            check(8'(core_supply_enable_out), 8'(low < 1000));
            check(8'(pll_enable), 8'(low < 1000));
            reset_pin_n = 1'b1;
        end
        repeat (6) @(negedge clk);
        check(8'(core_supply_enable_out), 8'h1);
        for (n = 0; n < 3000 && operational !== 1'b1 && boot_timeout !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == 3000) begin
            check(8'h0, 8'h1);
            hung = 1;
            return;
        end
        repeat (4) @(negedge clk);
        es = exp_q.pop_front();
        check(8'(boot_sense), 8'(es));
        check(8'(gpio9_is_flash_chip_select), 8'(s[2]));
        check(8'(operational), 8'(exp_q.pop_front()));
        check(8'(host_bus_port_spi), 8'(exp_q.pop_front()));
        check(8'(boot_timeout), 8'(exp_q.pop_front()));
        check(8'(internal_regulator_on), 8'(!sel));
        check(8'(host_interrupt_n), 8'h1);
        check(8'(strap_pins_free), 8'h1);
        // Straps reused as keypad lines must not disturb the stored sense
        strap_pins = ~s;
        repeat (3) @(negedge clk);
        check(8'(boot_sense), 8'(es));
    endtask : run

    initial begin
        rstn = 1'b0;
        reset_pin_n = 1'b1;
        supply_source_select = 1'b0;
        strap_pins = 3'h0;
        stall = 1'b0;
        use_spi = 1'b0;
        lat = 4'($urandom(2350));
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        run(0, 3'h0, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            run(lows[i % 4], 3'(i), 1'(i / 4), 1'($urandom), 1'b0);
        end
        run(1100, 3'h4, 1'b1, 1'b0, 1'b1);
        run(100, 3'h5, 1'b0, 1'b1, 1'b0);
        run(20, 3'h1, 1'b1, 1'b1, 1'b0);
        close_out();
    end

endmodule : reset_boot_sequencer_tb

`default_nettype wire
